// >>> core/cwpr_core.sv
// Operation
// R1: data memory access stays open when protected
// R2: programmed bit reads zero, decode inverted
// R3: setup word lives at address 2007h
// R4: config space reachable only in programming mode
// R5: power-up delay 72 ms, power-up only
// R6: hold reset until oscillator stable
// R7: watchdog enabled by setup bit, own clock
// R8: brown-out forces device reset
// R9: sleep exits on reset, watchdog, interrupt
// R10: bit 13 selects program memory protection
// R11: setup bits 12 to 9 read zero
// R12: bit 6 set enables brown-out reset
// R13: setup word latched before reset release
// R14: protected reads return fixed masked value
module cwpr_core (
  // system
  input wire logic aclk,
  input wire logic aresetn,
  // watchdog rc oscillator tick, synchronous one-cycle enable
  input wire logic wdt_osc_tick,
  // non-volatile setup word as stored
  input wire logic [13:0] nv_setup_word,
  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // device state
  output logic core_reset,
  output logic data_mem_access_en,
  output logic [13:0] setup_word_out
);
  cwpr_wdt_if wif();

  // bus slave state
  logic aw_got_reg, aw_got_next;
  logic w_got_reg, w_got_next;
  logic [7:0] awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;
  // software state
  logic [8:0] ctrl_reg, ctrl_next;
  logic [13:0] paddr_reg, paddr_next;
  logic [13:0] pwdata_reg, pwdata_next;
  logic [13:0] prdata_reg, prdata_next;
  logic access_err_reg, access_err_next;
  // device state
  logic [13:0] setup_reg, setup_next;
  cwpr_pkg::cwpr_state_t state_reg, state_next;
  logic [cwpr_pkg::CWPR_CNT_W-1:0] cnt_reg, cnt_next;
  logic core_reset_reg, core_reset_next;
  logic sleep_reg, sleep_next;
  logic wdt_to_reg, wdt_to_next;
  logic por_seen_reg, por_seen_next;

  logic wr_fire, rd_fire;
  logic [31:0] wmask;
  logic prot_on, bor_en, wdt_en, powerup_delay_timer_en, dprot_on;
  logic [13:0] prot_top;
  logic in_cfg_space, in_prot;
  logic [31:0] status_word;

  // R2: programmed bits read as zero, so protect, data-protect and delay-timer options are low; brown-out and watchdog are high
  // R10: bit 13 low protects program memory
  assign prot_on = !setup_reg[cwpr_pkg::CWPR_BIT_PROTECT];
  // R12: brown-out reset enabled when bit 6 is one
  assign bor_en = setup_reg[cwpr_pkg::CWPR_BIT_BOR_EN];
  assign wdt_en = setup_reg[cwpr_pkg::CWPR_BIT_WDT_EN];
  assign powerup_delay_timer_en = !setup_reg[cwpr_pkg::CWPR_BIT_POWERUP_DELAY_TIMER_EN];
  assign dprot_on = !setup_reg[cwpr_pkg::CWPR_BIT_DATA_PROT];

  always_comb begin
    unique case (cwpr_pkg::CWPR_MEM_SIZE)
      cwpr_pkg::CWPR_SIZE_4K: prot_top = cwpr_pkg::CWPR_TOP_4K;
      cwpr_pkg::CWPR_SIZE_2K: prot_top = cwpr_pkg::CWPR_TOP_2K;
      default: prot_top = cwpr_pkg::CWPR_TOP_1K;
    endcase
  end

  assign in_cfg_space = paddr_reg >= cwpr_pkg::CWPR_CFG_SPACE_LO;
  assign in_prot = prot_on && (paddr_reg <= prot_top);

  // R7: watchdog gated by setup bit, counted on its own oscillator tick
  assign wif.enable = wdt_en && !core_reset_reg;
  assign wif.tick = wdt_osc_tick;
  assign wif.clear = core_reset_reg;
  cwpr_wdt u_wdt (
    .aclk(aclk),
    .aresetn(aresetn),
    .w(wif)
  );

  assign wr_fire = aw_got_reg && w_got_reg && !bvalid_reg;
  assign rd_fire = s_axi_arvalid && !rvalid_reg;
  assign wmask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}}, {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[cwpr_pkg::CWPR_ST_CORE_RESET] = core_reset_reg;
    status_word[cwpr_pkg::CWPR_ST_SLEEPING] = sleep_reg;
    status_word[cwpr_pkg::CWPR_ST_PROTECTED] = prot_on;
    status_word[cwpr_pkg::CWPR_ST_BOR_EN] = bor_en;
    status_word[cwpr_pkg::CWPR_ST_WDT_EN] = wdt_en;
    status_word[cwpr_pkg::CWPR_ST_POWERUP_DELAY_TIMER_EN] = powerup_delay_timer_en;
    status_word[cwpr_pkg::CWPR_ST_DATA_PROT] = dprot_on;
    status_word[cwpr_pkg::CWPR_ST_WDT_TIMEOUT] = wdt_to_reg;
    status_word[cwpr_pkg::CWPR_ST_ACCESS_ERR] = access_err_reg;
  end

  // bus slave: aw and w taken independently, response after both
  always_comb begin
    aw_got_next = aw_got_reg;
    w_got_next = w_got_reg;
    awaddr_next = awaddr_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (s_axi_awvalid && !aw_got_reg) begin
      aw_got_next = 1'b1;
      awaddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_got_reg) begin
      w_got_next = 1'b1;
      wdata_next = s_axi_wdata;
      wstrb_next = s_axi_wstrb;
    end
    if (wr_fire) begin
      aw_got_next = 1'b0;
      w_got_next = 1'b0;
      bvalid_next = 1'b1;
      unique case (awaddr_reg)
        cwpr_pkg::CWPR_OFF_CTRL, cwpr_pkg::CWPR_OFF_PROG_ADDR, cwpr_pkg::CWPR_OFF_PROG_WDATA: bresp_next = 2'h0;
        default: bresp_next = 2'h2;
      endcase
    end else if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    if (rd_fire) begin
      rvalid_next = 1'b1;
      rresp_next = 2'h0;
      unique case (s_axi_araddr)
        cwpr_pkg::CWPR_OFF_CTRL: rdata_next = {23'h000000, ctrl_reg};
        cwpr_pkg::CWPR_OFF_STATUS: rdata_next = status_word;
        cwpr_pkg::CWPR_OFF_PROG_ADDR: rdata_next = {18'h00000, paddr_reg};
        cwpr_pkg::CWPR_OFF_PROG_WDATA: rdata_next = {18'h00000, pwdata_reg};
        cwpr_pkg::CWPR_OFF_PROG_RDATA: rdata_next = {18'h00000, prdata_reg};
        cwpr_pkg::CWPR_OFF_SETUP_WORD: rdata_next = {18'h00000, setup_reg};
        default: begin
          rdata_next = 32'h0000_0000;
          rresp_next = 2'h2;
        end
      endcase
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
  end

  // software registers and the programming port
  always_comb begin
    logic [31:0] merged;
    merged = 32'h0000_0000;
    ctrl_next = ctrl_reg;
    ctrl_next[cwpr_pkg::CWPR_CTRL_PROG_WR] = 1'b0;
    ctrl_next[cwpr_pkg::CWPR_CTRL_PROG_RD] = 1'b0;
    ctrl_next[cwpr_pkg::CWPR_CTRL_WAKE_INT] = 1'b0;
    ctrl_next[cwpr_pkg::CWPR_CTRL_EXT_RESET] = 1'b0;
    ctrl_next[cwpr_pkg::CWPR_CTRL_POWER_ON] = 1'b0;
    ctrl_next[cwpr_pkg::CWPR_CTRL_SLEEP] = 1'b0;
    paddr_next = paddr_reg;
    pwdata_next = pwdata_reg;
    prdata_next = prdata_reg;
    access_err_next = access_err_reg;
    setup_next = setup_reg;
    if (wr_fire) begin
      unique case (awaddr_reg)
        cwpr_pkg::CWPR_OFF_CTRL: begin
          merged = ({23'h000000, ctrl_reg} & ~wmask) | (wdata_reg & wmask);
          ctrl_next = merged[8:0];
          access_err_next = 1'b0;
        end
        cwpr_pkg::CWPR_OFF_PROG_ADDR: begin
          merged = ({18'h00000, paddr_reg} & ~wmask) | (wdata_reg & wmask);
          paddr_next = merged[13:0];
        end
        cwpr_pkg::CWPR_OFF_PROG_WDATA: begin
          merged = ({18'h00000, pwdata_reg} & ~wmask) | (wdata_reg & wmask);
          pwdata_next = merged[13:0];
        end
        default: begin
        end
      endcase
    end
    // R4: config space needs programming mode; error flag sticky, set wins
    if (ctrl_reg[cwpr_pkg::CWPR_CTRL_PROG_WR] || ctrl_reg[cwpr_pkg::CWPR_CTRL_PROG_RD]) begin
      if (!ctrl_reg[cwpr_pkg::CWPR_CTRL_PROG_MODE]) begin
        access_err_next = 1'b1;
      end else if (ctrl_reg[cwpr_pkg::CWPR_CTRL_PROG_WR]) begin
        // R3: the setup word sits at 2007h
        if (paddr_reg == cwpr_pkg::CWPR_SETUP_ADDR) begin
          // R11: unimplemented bits forced to zero
          setup_next = pwdata_reg & ~cwpr_pkg::CWPR_UNIMPL_MASK;
        end else begin
          access_err_next = 1'b1;
        end
      end else if (paddr_reg == cwpr_pkg::CWPR_SETUP_ADDR) begin
        prdata_next = setup_reg;
      end else if (in_prot) begin
        // R14: protected program memory reads back masked
        prdata_next = cwpr_pkg::CWPR_MASKED_READ;
      end else if (in_cfg_space) begin
        prdata_next = cwpr_pkg::CWPR_SETUP_ERASED;
      end else begin
        prdata_next = cwpr_pkg::CWPR_SETUP_ERASED;
      end
    end
    // R13: reload setup word from storage on a power-on request, as reset is entered
    if (ctrl_reg[cwpr_pkg::CWPR_CTRL_POWER_ON]) begin
      setup_next = nv_setup_word & ~cwpr_pkg::CWPR_UNIMPL_MASK;
    end
  end

  // reset sequencer and sleep
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    core_reset_next = core_reset_reg;
    sleep_next = sleep_reg;
    wdt_to_next = wdt_to_reg;
    por_seen_next = 1'b1;
    if (wif.timeout) begin
      wdt_to_next = 1'b1;
    end
    if (ctrl_reg[cwpr_pkg::CWPR_CTRL_SLEEP] && state_reg == cwpr_pkg::CWPR_S_RUN) begin
      sleep_next = 1'b1;
    end
    // R9: wake on interrupt or watchdog; external reset handled below
    if (sleep_reg && (ctrl_reg[cwpr_pkg::CWPR_CTRL_WAKE_INT] || wif.timeout)) begin
      sleep_next = 1'b0;
    end
    unique case (state_reg)
      cwpr_pkg::CWPR_S_POWERUP_DELAY_TIMER: begin
        core_reset_next = 1'b1;
        // R5: 72 ms hold, skipped when disabled
        if (!powerup_delay_timer_en || cnt_reg >= cwpr_pkg::CWPR_CNT_W'(cwpr_pkg::CWPR_POWERUP_DELAY_TIMER_CYCLES - 1)) begin
          state_next = cwpr_pkg::CWPR_S_OST;
          cnt_next = '0;
        end else begin
          cnt_next = cnt_reg + 1'b1;
        end
      end
      cwpr_pkg::CWPR_S_OST: begin
        core_reset_next = 1'b1;
        // R6: release only once the oscillator is stable
        if (ctrl_reg[cwpr_pkg::CWPR_CTRL_OSC_STABLE]) begin
          state_next = cwpr_pkg::CWPR_S_RUN;
          core_reset_next = 1'b0;
        end
      end
      cwpr_pkg::CWPR_S_RUN: begin
        core_reset_next = 1'b0;
      end
    endcase
    // non power-up resets skip the delay timer
    if (ctrl_reg[cwpr_pkg::CWPR_CTRL_EXT_RESET] || (wif.timeout && !sleep_reg)
        // R8: brown-out forces reset when enabled
        || (bor_en && ctrl_reg[cwpr_pkg::CWPR_CTRL_BROWNOUT])) begin
      state_next = cwpr_pkg::CWPR_S_OST;
      core_reset_next = 1'b1;
      sleep_next = 1'b0;
    end
    if (ctrl_reg[cwpr_pkg::CWPR_CTRL_POWER_ON] || !por_seen_reg) begin
      state_next = cwpr_pkg::CWPR_S_POWERUP_DELAY_TIMER;
      cnt_next = '0;
      core_reset_next = 1'b1;
      sleep_next = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= 2'h0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= 2'h0;
      ctrl_reg <= 9'h000;
      paddr_reg <= 14'h0000;
      pwdata_reg <= 14'h0000;
      prdata_reg <= 14'h0000;
      access_err_reg <= 1'b0;
      setup_reg <= cwpr_pkg::CWPR_SETUP_ERASED & ~cwpr_pkg::CWPR_UNIMPL_MASK;
      state_reg <= cwpr_pkg::CWPR_S_POWERUP_DELAY_TIMER;
      cnt_reg <= '0;
      core_reset_reg <= 1'b1;
      sleep_reg <= 1'b0;
      wdt_to_reg <= 1'b0;
      por_seen_reg <= 1'b0;
    end else begin
      aw_got_reg <= aw_got_next;
      w_got_reg <= w_got_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
      ctrl_reg <= ctrl_next;
      paddr_reg <= paddr_next;
      pwdata_reg <= pwdata_next;
      prdata_reg <= prdata_next;
      access_err_reg <= access_err_next;
      // first cycle after bus reset acts as power-on, loading storage
      setup_reg <= por_seen_reg ? setup_next : (nv_setup_word & ~cwpr_pkg::CWPR_UNIMPL_MASK);
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      core_reset_reg <= core_reset_next;
      sleep_reg <= sleep_next;
      wdt_to_reg <= wdt_to_next;
      por_seen_reg <= por_seen_next;
    end
  end

  assign s_axi_awready = !aw_got_reg;
  assign s_axi_wready = !w_got_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign core_reset = core_reset_reg;
  // R1: data memory stays usable whatever the protect setting
  assign data_mem_access_en = !core_reset_reg;
  assign setup_word_out = setup_reg;
endmodule

// >>> core/cwpr_wdt.sv
module cwpr_wdt (
  input wire logic aclk,
  input wire logic aresetn,
  cwpr_wdt_if.timer w
);
  logic [15:0] cnt_reg, cnt_next;
  logic to_reg, to_next;
  assign w.timeout = to_reg;
  // counts only on ticks of its own rc oscillator
  always_comb begin
    cnt_next = cnt_reg;
    to_next = 1'b0;
    if (!w.enable || w.clear) begin
      cnt_next = 16'h0000;
    end else if (w.tick) begin
      if (cnt_reg == 16'(cwpr_pkg::CWPR_WDT_PERIOD - 1)) begin
        cnt_next = 16'h0000;
        to_next = 1'b1;
      end else begin
        cnt_next = cnt_reg + 16'h0001;
      end
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= 16'h0000;
      to_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      to_reg <= to_next;
    end
  end
endmodule

// >>> dv/cwpr_core_assertions.sv
module cwpr_core_assertions (
  // system
  input wire logic aclk,
  input wire logic aresetn,
  // bus
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // device state
  input wire logic core_reset,
  input wire logic data_mem_access_en,
  input wire logic [13:0] setup_word_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("write response late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
    else $error("read data late");
  a_unimpl_zero: assert property (setup_word_out[12:9] == 4'h0)
    else $error("unimplemented setup bits not zero");
  a_data_open: assert property (data_mem_access_en == !core_reset)
    else $error("data memory access not tied to run state");
  a_reset_first: assert property ($rose(aresetn) |-> core_reset)
    else $error("core left reset at release");
  a_word_latched: assert property ($fell(core_reset) |-> $stable(setup_word_out))
    else $error("setup word changed at reset release");
  a_brownout_rst: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    && s_axi_awaddr == 8'h00 && s_axi_wdata[6] && setup_word_out[6] |-> ##[1:4] core_reset)
    else $error("brown-out did not reset core");
endmodule

bind cwpr_core cwpr_core_assertions i_chk (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .core_reset, .data_mem_access_en, .setup_word_out);

// >>> dv/cwpr_core_bench.sv
module cwpr_core_bench;
  timeunit 1ns;
  timeprecision 1ps;
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic tick_en = 1'b0;
  logic wdt_osc_tick;
  logic [13:0] nv_setup_word;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, core_reset, data_mem_access_en;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, rd_d;
  logic [13:0] setup_word_out;
  logic [31:0] ctrl_lvl = 32'h0;
  int miscompares = 0;
  int num_checks = 0;

  always #20 aclk = ~aclk;

  cwpr_nv_model i_nv (.aclk, .tick_en, .nv_setup_word, .wdt_osc_tick);
  cwpr_core i_dut (.aclk, .aresetn, .wdt_osc_tick, .nv_setup_word, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .core_reset, .data_mem_access_en, .setup_word_out);

  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    bit aw_done = 1'b0;
    bit w_done = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (!aw_done && s_axi_awready === 1'b1) begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_done && s_axi_wready === 1'b1) begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    // bready held back so the response must wait for it
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    s_axi_bready <= 1'b1;
    @(posedge aclk);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axr(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    @(posedge aclk);
    while (s_axi_arready !== 1'b1) @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    @(posedge aclk);
    // rready held back so the read data must wait for it
    while (s_axi_rvalid !== 1'b1) @(posedge aclk);
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    rd_d = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic chk_rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
    axr(a);
    `CHK(nm, e, rd_d & m)
  endtask

  // level bits ride along with every pulse
  task automatic ctrl(input logic [31:0] p);
    axw(cwpr_pkg::CWPR_OFF_CTRL, ctrl_lvl | p);
  endtask

  task automatic prog_rd(input logic [13:0] a, input logic [31:0] e);
    axw(cwpr_pkg::CWPR_OFF_PROG_ADDR, {18'h0, a});
    ctrl(32'h4);
    chk_rd(cwpr_pkg::CWPR_OFF_PROG_RDATA, 32'h3FFF, e, "prog_rdata");
  endtask

  task automatic wait_rst(input logic e, input string nm);
    for (int n = 0; n < 32 && core_reset !== e; n++) @(posedge aclk);
    `CHK(nm, e, core_reset)
  endtask

  task automatic boot(input logic [13:0] w);
    i_nv.program_word(w);
    aresetn <= 1'b0;
    ctrl_lvl = 32'h0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (40) @(posedge aclk);
    `CHK("reset_no_osc", 1'b1, core_reset)
    ctrl_lvl = 32'h80;
    ctrl(32'h0);
  endtask

  task automatic end_sim;
    if (miscompares == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    #2_000_000;
    miscompares++;
    end_sim();
  end

  initial begin
    // protected, data protected, brown-out on, power-up delay off
    boot(14'h1E48);
    wait_rst(1'b0, "core_run");
    `CHK("data_access", 1'b1, data_mem_access_en)
    chk_rd(cwpr_pkg::CWPR_OFF_SETUP_WORD, 32'hFFFFFFFF, 32'h0048, "setup_word");
    chk_rd(cwpr_pkg::CWPR_OFF_STATUS, 32'h7C, 32'h4C, "decode_a");
    axw(cwpr_pkg::CWPR_OFF_PROG_ADDR, 32'h2007);
    ctrl(32'h4);
    chk_rd(cwpr_pkg::CWPR_OFF_STATUS, 32'h100, 32'h100, "no_prog_mode");
    ctrl_lvl = 32'h81;
    ctrl(32'h0);
    chk_rd(cwpr_pkg::CWPR_OFF_STATUS, 32'h100, 32'h0, "err_clear");
    prog_rd(14'h2007, 32'h0048);
    prog_rd(14'h0FFF, 32'h0);
    prog_rd(14'h1000, 32'h3FFF);
    axw(cwpr_pkg::CWPR_OFF_PROG_WDATA, 32'h3FFF);
    axw(cwpr_pkg::CWPR_OFF_PROG_ADDR, 32'h2006);
    ctrl(32'h2);
    chk_rd(cwpr_pkg::CWPR_OFF_STATUS, 32'h100, 32'h100, "wr_off_word");
    axw(cwpr_pkg::CWPR_OFF_PROG_ADDR, 32'h2007);
    ctrl(32'h2);
    chk_rd(cwpr_pkg::CWPR_OFF_SETUP_WORD, 32'hFFFFFFFF, 32'h21FF, "prog_word");
    ctrl_lvl = 32'hC0;
    ctrl(32'h0);
    wait_rst(1'b1, "brownout");
    ctrl_lvl = 32'h80;
    ctrl(32'h0);
    wait_rst(1'b0, "brownout_end");
    // interrupt wake, then external reset wake
    for (int k = 0; k < 2; k++) begin
      ctrl(32'h8);
      chk_rd(cwpr_pkg::CWPR_OFF_STATUS, 32'h2, 32'h2, "asleep");
      ctrl(k == 0 ? 32'h10 : 32'h20);
      wait_rst(1'b0, "wake_run");
      chk_rd(cwpr_pkg::CWPR_OFF_STATUS, 32'h2, 32'h0, "woken");
    end
    axr(8'h18);
    `CHK("rresp_unmapped", 2'h2, rsp)
    axw(8'h18, 32'h0);
    `CHK("bresp_unmapped", 2'h2, rsp)
    axw(cwpr_pkg::CWPR_OFF_STATUS, 32'h0);
    `CHK("bresp_readonly", 2'h2, rsp)
    // unprotected, brown-out off, watchdog on
    boot(14'h3FBF);
    wait_rst(1'b0, "core_run_c");
    chk_rd(cwpr_pkg::CWPR_OFF_STATUS, 32'h7C, 32'h10, "decode_c");
    ctrl_lvl = 32'h81;
    ctrl(32'h0);
    prog_rd(14'h0100, 32'h3FFF);
    ctrl_lvl = 32'hC0;
    ctrl(32'h0);
    repeat (8) @(posedge aclk);
    `CHK("bor_disabled", 1'b0, core_reset)
    ctrl_lvl = 32'h80;
    ctrl(32'h0);
    tick_en <= 1'b1;
    ctrl(32'h8);
    repeat (4400) @(posedge aclk);
    chk_rd(cwpr_pkg::CWPR_OFF_STATUS, 32'h2, 32'h0, "wdt_wake");
    repeat (4400) @(posedge aclk);
    chk_rd(cwpr_pkg::CWPR_OFF_STATUS, 32'h80, 32'h80, "wdt_timeout");
    tick_en <= 1'b0;
    // power-up delay on, reloaded by a power-on request
    i_nv.program_word(14'h3FF7);
    ctrl(32'h100);
    repeat (300) @(posedge aclk);
    `CHK("powerup_delay_timer_hold", 1'b1, core_reset)
    `CHK("word_reload", 14'h21F7, setup_word_out)
    end_sim();
  end
endmodule

// >>> dv/cwpr_nv_model.sv
module cwpr_nv_model (
  // system
  input wire logic aclk,
  // oscillator gate
  input wire logic tick_en,
  // towards the device
  output logic [13:0] nv_setup_word,
  output logic wdt_osc_tick
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] div_reg = 2'h0;
  // erased storage until the programmer writes it
  initial nv_setup_word = 14'h3FFF;
  task automatic program_word(input logic [13:0] w);
    @(posedge aclk);
    nv_setup_word <= w;
  endtask
  always @(posedge aclk) begin
    div_reg <= div_reg + 2'h1;
  end
  assign wdt_osc_tick = tick_en && (div_reg == 2'h3);
endmodule

// >>> pkg/cwpr_pkg.sv
package cwpr_pkg;
  // register byte addresses on the bus
  localparam logic [7:0] CWPR_OFF_CTRL = 8'h00;
  localparam logic [7:0] CWPR_OFF_STATUS = 8'h04;
  localparam logic [7:0] CWPR_OFF_PROG_ADDR = 8'h08;
  localparam logic [7:0] CWPR_OFF_PROG_WDATA = 8'h0C;
  localparam logic [7:0] CWPR_OFF_PROG_RDATA = 8'h10;
  localparam logic [7:0] CWPR_OFF_SETUP_WORD = 8'h14;
  // control register fields
  localparam int CWPR_CTRL_PROG_MODE = 0;
  localparam int CWPR_CTRL_PROG_WR = 1;
  localparam int CWPR_CTRL_PROG_RD = 2;
  localparam int CWPR_CTRL_SLEEP = 3;
  localparam int CWPR_CTRL_WAKE_INT = 4;
  localparam int CWPR_CTRL_EXT_RESET = 5;
  localparam int CWPR_CTRL_BROWNOUT = 6;
  localparam int CWPR_CTRL_OSC_STABLE = 7;
  localparam int CWPR_CTRL_POWER_ON = 8;
  // status register fields
  localparam int CWPR_ST_CORE_RESET = 0;
  localparam int CWPR_ST_SLEEPING = 1;
  localparam int CWPR_ST_PROTECTED = 2;
  localparam int CWPR_ST_BOR_EN = 3;
  localparam int CWPR_ST_WDT_EN = 4;
  localparam int CWPR_ST_POWERUP_DELAY_TIMER_EN = 5;
  localparam int CWPR_ST_DATA_PROT = 6;
  localparam int CWPR_ST_WDT_TIMEOUT = 7;
  localparam int CWPR_ST_ACCESS_ERR = 8;
  // setup word layout, 14 bits, programmed bit reads 0
  localparam logic [13:0] CWPR_SETUP_ADDR = 14'h2007;
  localparam logic [13:0] CWPR_CFG_SPACE_LO = 14'h2000;
  localparam int CWPR_BIT_PROTECT = 13;
  localparam int CWPR_BIT_DATA_PROT = 8;
  localparam int CWPR_BIT_BOR_EN = 6;
  localparam int CWPR_BIT_POWERUP_DELAY_TIMER_EN = 3;
  localparam int CWPR_BIT_WDT_EN = 2;
  localparam logic [13:0] CWPR_UNIMPL_MASK = 14'h1E00;
  localparam logic [13:0] CWPR_SETUP_ERASED = 14'h3FFF;
  // protected range top per memory size
  localparam logic [1:0] CWPR_SIZE_4K = 2'h2;
  localparam logic [1:0] CWPR_SIZE_2K = 2'h1;
  localparam logic [13:0] CWPR_TOP_4K = 14'h0FFF;
  localparam logic [13:0] CWPR_TOP_2K = 14'h07FF;
  localparam logic [13:0] CWPR_TOP_1K = 14'h03FF;
  localparam logic [1:0] CWPR_MEM_SIZE = CWPR_SIZE_4K;
  localparam logic [13:0] CWPR_MASKED_READ = 14'h0000;
  // timing
  localparam int CWPR_CLK_HZ = 25_000_000;
  localparam int CWPR_POWERUP_DELAY_TIMER_MS = 72;
  localparam int CWPR_POWERUP_DELAY_TIMER_CYCLES = CWPR_POWERUP_DELAY_TIMER_MS * (CWPR_CLK_HZ / 1000);
  localparam int CWPR_WDT_PERIOD = 1024;
  localparam int CWPR_CNT_W = 22;
  typedef enum logic [1:0] {CWPR_S_POWERUP_DELAY_TIMER, CWPR_S_OST, CWPR_S_RUN} cwpr_state_t;
endpackage

// >>> pkg/cwpr_wdt_if.sv
interface cwpr_wdt_if;
  logic enable;
  logic tick;
  logic clear;
  logic timeout;
  modport owner(output enable, output tick, output clear, input timeout);
  modport timer(input enable, input tick, input clear, output timeout);
endinterface
